// ==== cpu_operand_address_and_stack.sv ====
// Operand address generation and stack pointer sequencing
// Functional notes
// RULE_01 - Call or interrupt pushes return address first; code pushes on SOP_CALL only, has no interrupt entry
// RULE_02 - Subroutine return reloads only program counter
// RULE_03 - Interrupt return reloads counter and flags
// RULE_04 - Pointer names next save; post-dec, pre-inc
// RULE_05 - Register mode selects registers, no memory
// RULE_06 - Immediate operand byte is data itself
// RULE_07 - Direct-page operand byte forms page address
// RULE_08 - Absolute: low byte then high byte
// RULE_09 - Absolute serves read-modify-write memory operations
// RULE_10 - X mode addresses page by X alone
// RULE_11 - X auto-increment accesses then bumps X
// RULE_12 - Operand plus X within direct page
// RULE_13 - Operand plus Y within direct page
// RULE_14 - Indexed sums wrap to eight bits
`include "opaddr_defs.svh"
module cpu_operand_address_and_stack
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic req_i,
   input wire opaddr_pkg::addr_mode_t mode_i,
   input wire opaddr_pkg::reg_sel_t reg_sel_i,
   input wire logic is_store_i,
   input wire logic [7:0] op1_i,
   input wire logic [7:0] op2_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] x_i,
   input wire logic [7:0] y_i,
   input wire logic [7:0] psw_i,
   input wire logic page_sel_i,
   input wire opaddr_pkg::stack_op_t stack_op_i,
   input wire logic [15:0] ret_pc_i,
   input wire logic sp_load_i,
   input wire logic [7:0] sp_load_val_i,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_rmw_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic [7:0] operand_o,
   output logic operand_valid_o,
   output logic x_wr_o,
   output logic [7:0] x_new_o,
   output logic [7:0] stack_pointer_o,
   output logic stack_busy_o,
   output logic pc_load_o,
   output logic [15:0] pc_new_o,
   output logic psw_load_o,
   output logic [7:0] psw_new_o,
   output logic jump_ok_o
);
   import opaddr_pkg::*;
   typedef struct packed {
      stack_state_t st;
      logic [7:0] sp;
      logic [15:0] ret;
      logic return_from_interrupt;
      logic [7:0] pc_lo;
      logic mem_req;
      logic mem_we;
      logic mem_rmw;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
      logic [7:0] operand;
      logic operand_valid;
      logic x_wr;
      logic [7:0] x_new;
      logic pc_load;
      logic [15:0] pc_new;
      logic psw_load;
      logic [7:0] psw_new;
      logic jump_ok;
      logic busy;
   } state_t;
   state_t s_reg;
   state_t s_next;
   logic [15:0] ea;
   logic ea_mem;
   logic ea_imm;
   logic [7:0] page;
   logic [7:0] sp_inc;
   assign page = page_sel_i ? `OPA_DP_PAGE1 : `OPA_DP_PAGE0;
   assign sp_inc = 8'(s_reg.sp + 8'h01);
   opaddr_ea u_ea
   (
      .mode_i(mode_i),
      .op1_i(op1_i),
      .op2_i(op2_i),
      .x_i(x_i),
      .y_i(y_i),
      .page_i(page),
      .addr_o(ea),
      .mem_o(ea_mem),
      .imm_o(ea_imm)
   );
   always_comb
   begin
      s_next = s_reg;
      s_next.mem_req = 1'b0;
      s_next.mem_we = 1'b0;
      s_next.mem_rmw = 1'b0;
      s_next.operand_valid = 1'b0;
      s_next.x_wr = 1'b0;
      s_next.pc_load = 1'b0;
      s_next.psw_load = 1'b0;
      s_next.jump_ok = 1'b0;
      unique case (s_reg.st)
         ST_IDLE:
         begin
            if (sp_load_i)
            begin
               s_next.sp = sp_load_val_i;
            end
            else if (stack_op_i == SOP_CALL)
            begin
               s_next.ret = ret_pc_i;
               s_next.st = ST_PUSH_HI;
            end
            else if (stack_op_i == SOP_RET || stack_op_i == SOP_RETURN_FROM_INTERRUPT)
            begin
               s_next.return_from_interrupt = (stack_op_i == SOP_RETURN_FROM_INTERRUPT);
               s_next.st = (stack_op_i == SOP_RETURN_FROM_INTERRUPT) ? ST_POP_PSW : ST_POP_LO;
            end
            else if (req_i)
            begin
               if (mode_i == AM_REG)
               begin
                  s_next.operand_valid = 1'b1; // RULE_05
                  unique case (reg_sel_i)
                     RSEL_ACC: s_next.operand = acc_i;
                     RSEL_X: s_next.operand = x_i;
                     RSEL_Y: s_next.operand = y_i;
                     RSEL_PSW: s_next.operand = psw_i;
                  endcase
               end
               else if (ea_imm)
               begin
                  s_next.operand = op1_i; // RULE_06
                  s_next.operand_valid = 1'b1;
               end
               else if (ea_mem)
               begin
                  s_next.mem_req = 1'b1;
                  s_next.mem_addr = ea;
                  s_next.mem_rmw = (mode_i == AM_ABS_RMW); // RULE_09
                  s_next.mem_we = is_store_i && mode_i != AM_ABS_RMW;
                  s_next.mem_wdata = acc_i;
                  if (mode_i == AM_XINC)
                  begin
                     s_next.x_wr = 1'b1; // RULE_11
                     s_next.x_new = 8'(x_i + 8'h01);
                  end
               end
            end
         end
         // Return address high byte first so the low byte pops first
         ST_PUSH_HI:
         begin
            s_next.mem_req = 1'b1;
            s_next.mem_we = 1'b1;
            s_next.mem_addr = {`OPA_DP_PAGE1, s_reg.sp};
            s_next.mem_wdata = s_reg.ret[15:8]; // RULE_01
            s_next.sp = 8'(s_reg.sp - 8'h01); // RULE_04
            s_next.st = ST_PUSH_LO;
         end
         ST_PUSH_LO:
         begin
            s_next.mem_req = 1'b1;
            s_next.mem_we = 1'b1;
            s_next.mem_addr = {`OPA_DP_PAGE1, s_reg.sp};
            s_next.mem_wdata = s_reg.ret[7:0]; // RULE_01
            s_next.sp = 8'(s_reg.sp - 8'h01); // RULE_04
            s_next.jump_ok = 1'b1; // RULE_01
            s_next.st = ST_IDLE;
         end
         ST_POP_PSW:
         begin
            s_next.mem_req = 1'b1;
            s_next.mem_addr = {`OPA_DP_PAGE1, sp_inc}; // RULE_04
            s_next.sp = sp_inc;
            s_next.st = ST_POP_LO;
         end
         ST_POP_LO:
         begin
            s_next.mem_req = 1'b1;
            s_next.mem_addr = {`OPA_DP_PAGE1, sp_inc}; // RULE_04
            s_next.sp = sp_inc;
            s_next.st = ST_POP_HI;
         end
         // Read data trails its request by one cycle, so the flags byte
         // asked for two states back is on the bus here
         ST_POP_HI:
         begin
            s_next.mem_req = 1'b1;
            s_next.mem_addr = {`OPA_DP_PAGE1, sp_inc}; // RULE_04
            s_next.sp = sp_inc;
            if (s_reg.return_from_interrupt)
            begin
               s_next.psw_new = mem_rdata_i; // RULE_03
               s_next.psw_load = 1'b1;
            end
            s_next.st = ST_GET_LO;
         end
         ST_GET_LO:
         begin
            s_next.pc_lo = mem_rdata_i;
            s_next.st = ST_GET_HI;
         end
         ST_GET_HI:
         begin
            s_next.pc_new = {mem_rdata_i, s_reg.pc_lo}; // RULE_02 RULE_03
            s_next.pc_load = 1'b1;
            s_next.st = ST_IDLE;
         end
         default: s_next.st = ST_IDLE;
      endcase
      // Busy follows the next state so the flag leaves a flip-flop
      s_next.busy = (s_next.st != ST_IDLE);
   end
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.sp <= `OPA_SP_RESET;
         s_reg.pc_new <= `OPA_PC_RESET;
      end
      else if (ce_i)
      begin
         s_reg <= s_next;
      end
   end
   assign mem_req_o = s_reg.mem_req;
   assign mem_we_o = s_reg.mem_we;
   assign mem_rmw_o = s_reg.mem_rmw;
   assign mem_addr_o = s_reg.mem_addr;
   assign mem_wdata_o = s_reg.mem_wdata;
   assign operand_o = s_reg.operand;
   assign operand_valid_o = s_reg.operand_valid;
   assign x_wr_o = s_reg.x_wr;
   assign x_new_o = s_reg.x_new;
   assign stack_pointer_o = s_reg.sp;
   assign stack_busy_o = s_reg.busy;
   assign pc_load_o = s_reg.pc_load;
   assign pc_new_o = s_reg.pc_new;
   assign psw_load_o = s_reg.psw_load;
   assign psw_new_o = s_reg.psw_new;
   assign jump_ok_o = s_reg.jump_ok;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_push_then_jump: assert property ((s_reg.st == ST_PUSH_LO) && ce_i
      |=> jump_ok_o && mem_we_o) // RULE_01
      else $error("jump not after push");
   a_ret_no_psw: assert property ((s_reg.st == ST_POP_HI) && !s_reg.return_from_interrupt
      && ce_i |=> !psw_load_o) // RULE_02
      else $error("return loaded flags");
   a_return_from_interrupt_psw: assert property ((s_reg.st == ST_POP_HI) && s_reg.return_from_interrupt
      && ce_i |=> psw_load_o) // RULE_03
      else $error("interrupt return missed flags");
   a_sp_push_dec: assert property ((s_reg.st == ST_PUSH_HI) && ce_i
      |=> stack_pointer_o == 8'($past(stack_pointer_o) - 8'h01)) // RULE_04
      else $error("stack pointer not decremented");
   a_sp_pop_pre: assert property ((s_reg.st == ST_POP_LO) && ce_i
      |=> mem_addr_o[7:0] == stack_pointer_o) // RULE_04
      else $error("pop not pre-incremented");
   a_reg_nomem: assert property (ce_i && req_i && mode_i == AM_REG
      && s_reg.st == ST_IDLE && stack_op_i == SOP_NONE && !sp_load_i
      |=> !mem_req_o && operand_valid_o) // RULE_05
      else $error("register mode touched memory");
   a_imm_data: assert property (ce_i && req_i && mode_i == AM_IMM
      && s_reg.st == ST_IDLE && stack_op_i == SOP_NONE && !sp_load_i
      |=> operand_o == $past(op1_i) && !mem_req_o) // RULE_06
      else $error("immediate not used as data");
   a_abs_addr: assert property (ce_i && req_i && mode_i == AM_ABS
      && s_reg.st == ST_IDLE && stack_op_i == SOP_NONE && !sp_load_i
      |=> mem_addr_o == {$past(op2_i), $past(op1_i)}) // RULE_08
      else $error("absolute address wrong");
   a_xinc_bump: assert property (ce_i && req_i && mode_i == AM_XINC
      && s_reg.st == ST_IDLE && stack_op_i == SOP_NONE && !sp_load_i
      |=> x_wr_o && x_new_o == 8'($past(x_i) + 8'h01)
      && mem_addr_o[7:0] == $past(x_i)) // RULE_11
      else $error("auto increment wrong");
   a_dpx_wrap: assert property (ce_i && req_i && mode_i == AM_DPX
      && s_reg.st == ST_IDLE && stack_op_i == SOP_NONE && !sp_load_i
      |=> mem_addr_o[15:8] == $past(page)
      && mem_addr_o[7:0] == 8'($past(op1_i) + $past(x_i))) // RULE_12 RULE_14
      else $error("indexed access left page");
   c_call: cover property (s_reg.st == ST_PUSH_LO ##1 jump_ok_o);
   c_return_from_interrupt: cover property (psw_load_o ##2 pc_load_o);
   c_xinc: cover property (x_wr_o);
endmodule // cpu_operand_address_and_stack

// ==== opaddr_defs.svh ====
// Constants for operand address generation and stack handling
`ifndef OPADDR_DEFS_SVH
`define OPADDR_DEFS_SVH
`define OPA_SP_RESET 8'h7F
`define OPA_DP_PAGE0 8'h00
`define OPA_DP_PAGE1 8'h01
`define OPA_PC_RESET 16'h0000
`endif

// ==== opaddr_pkg.sv ====
// Types for operand address generation and stack handling
package opaddr_pkg;
   typedef enum logic [3:0] {
      AM_REG = 4'h0,
      AM_IMM = 4'h1,
      AM_DP = 4'h2,
      AM_ABS = 4'h3,
      AM_X = 4'h4,
      AM_XINC = 4'h5,
      AM_DPX = 4'h6,
      AM_DPY = 4'h7,
      AM_ABS_RMW = 4'h8
   } addr_mode_t;
   typedef enum logic [1:0] {
      RSEL_ACC = 2'h0,
      RSEL_X = 2'h1,
      RSEL_Y = 2'h2,
      RSEL_PSW = 2'h3
   } reg_sel_t;
   typedef enum logic [1:0] {
      SOP_NONE = 2'h0,
      SOP_CALL = 2'h1,
      SOP_RET = 2'h2,
      SOP_RETURN_FROM_INTERRUPT = 2'h3
   } stack_op_t;
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_PUSH_HI = 8'b0000_0010,
      ST_PUSH_LO = 8'b0000_0100,
      ST_POP_PSW = 8'b0000_1000,
      ST_POP_LO = 8'b0001_0000,
      ST_POP_HI = 8'b0010_0000,
      ST_GET_LO = 8'b0100_0000,
      ST_GET_HI = 8'b1000_0000
   } stack_state_t;
endpackage

// ==== opaddr_ea.sv ====
// Combinational effective address former for data addressing modes
`include "opaddr_defs.svh"
module opaddr_ea
(
   input wire opaddr_pkg::addr_mode_t mode_i,
   input wire logic [7:0] op1_i,
   input wire logic [7:0] op2_i,
   input wire logic [7:0] x_i,
   input wire logic [7:0] y_i,
   input wire logic [7:0] page_i,
   output logic [15:0] addr_o,
   output logic mem_o,
   output logic imm_o
);
   import opaddr_pkg::*;
   logic [7:0] dp_off;
   always_comb
   begin
      dp_off = op1_i;
      mem_o = 1'b1;
      imm_o = 1'b0;
      addr_o = 16'h0000;
      unique case (mode_i)
         AM_REG:
         begin
            mem_o = 1'b0; // RULE_05
         end
         AM_IMM:
         begin
            mem_o = 1'b0; // RULE_06
            imm_o = 1'b1;
         end
         AM_DP: dp_off = op1_i; // RULE_07
         AM_ABS, AM_ABS_RMW: addr_o = {op2_i, op1_i}; // RULE_08
         AM_X, AM_XINC: dp_off = x_i; // RULE_10
         // Carry out dropped so the access never leaves the page
         AM_DPX: dp_off = 8'(op1_i + x_i); // RULE_12 RULE_14
         AM_DPY: dp_off = 8'(op1_i + y_i); // RULE_13 RULE_14
         default:
         begin
            mem_o = 1'b0;
         end
      endcase
      if (mode_i != AM_ABS && mode_i != AM_ABS_RMW && mem_o)
      begin
         addr_o = {page_i, dp_off};
      end
   end
endmodule // opaddr_ea

// ==== opaddr_mem_model.sv ====
// Data memory partner answering reads one cycle after the request
module opaddr_mem_model
(
   input wire logic clk_i,
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [65536];
   initial
   begin
      rdata_o = 8'h00;
      for (int i = 0; i < 65536; i++)
         mem[i] = i[7:0] ^ 8'hA5;
   end
   always @(posedge clk_i)
   begin
      if (mem_req_i && mem_we_i)
         mem[mem_addr_i] <= mem_wdata_i;
      // Stale data is scrambled so a late sample cannot pass by luck
      rdata_o <= (mem_req_i && !mem_we_i) ? mem[mem_addr_i] : ~rdata_o;
   end
endmodule // opaddr_mem_model

// ==== cpu_operand_address_and_stack_bench.sv ====
// Self-checking bench for operand addressing and stack sequencing
`include "opaddr_defs.svh"
module cpu_operand_address_and_stack_bench;
   import opaddr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] STACK_PAGE = 8'h01;
   logic clk_i, rstn_i, ce_i, req_i, is_store_i, page_sel_i, sp_load_i;
   addr_mode_t mode_i;
   reg_sel_t reg_sel_i;
   stack_op_t stack_op_i;
   logic [7:0] op1_i, op2_i, acc_i, x_i, y_i, psw_i, sp_load_val_i;
   logic [15:0] ret_pc_i, mem_addr_o, pc_new_o;
   logic [7:0] mem_rdata_i, mem_wdata_o, operand_o, x_new_o;
   logic [7:0] stack_pointer_o, psw_new_o;
   logic mem_req_o, mem_we_o, mem_rmw_o, operand_valid_o, x_wr_o;
   logic stack_busy_o, pc_load_o, psw_load_o, jump_ok_o;
   int n_mismatch, n_compared, seed, cycles, sp_m, npc, npsw, jw;
   logic [15:0] wa [$];
   logic [7:0] wd [$];
   logic [15:0] pcv, pa, pb;
   logic [7:0] pswv;

   cpu_operand_address_and_stack dut (.clk_i, .rstn_i, .ce_i, .req_i,
      .mode_i, .reg_sel_i, .is_store_i, .op1_i, .op2_i, .acc_i, .x_i, .y_i,
      .psw_i, .page_sel_i, .stack_op_i, .ret_pc_i, .sp_load_i,
      .sp_load_val_i, .mem_rdata_i, .mem_req_o, .mem_we_o, .mem_rmw_o,
      .mem_addr_o, .mem_wdata_o, .operand_o, .operand_valid_o, .x_wr_o,
      .x_new_o, .stack_pointer_o, .stack_busy_o, .pc_load_o, .pc_new_o,
      .psw_load_o, .psw_new_o, .jump_ok_o);

   opaddr_mem_model mem (.clk_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .rdata_o(mem_rdata_i));

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic addr_op(input addr_mode_t m);
      logic [7:0] pg;
      logic [15:0] ea;
      logic [7:0] regs [4];
      int k;
      @(posedge clk_i);
      #1;
      mode_i = m;
      reg_sel_i = reg_sel_t'(2'($random(seed)));
      is_store_i = 1'($random(seed));
      page_sel_i = 1'($random(seed));
      {op1_i, op2_i, acc_i, x_i, y_i, psw_i} =
         48'({$random(seed), $random(seed)});
      req_i = 1'b1;
      @(posedge clk_i);
      #1;
      req_i = 1'b0;
      pg = page_sel_i ? `OPA_DP_PAGE1 : `OPA_DP_PAGE0;
      regs = '{acc_i, x_i, y_i, psw_i};
      case (m)
         AM_DP: ea = {pg, op1_i};
         AM_ABS, AM_ABS_RMW: ea = {op2_i, op1_i};
         AM_X, AM_XINC: ea = {pg, x_i};
         AM_DPX: ea = {pg, 8'(op1_i + x_i)};
         AM_DPY: ea = {pg, 8'(op1_i + y_i)};
         default: ea = 16'h0000;
      endcase
      k = 0;
      while (mem_req_o !== 1'b1 && operand_valid_o !== 1'b1 && k < 4)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (m == AM_REG || m == AM_IMM)
      begin
         check("operand_valid", operand_valid_o, 1'b1);
         check("no_mem_req", mem_req_o, 1'b0);
         check("operand", operand_o,
            m == AM_IMM ? op1_i : regs[reg_sel_i]);
      end
      else
      begin
         check("mem_req", mem_req_o, 1'b1);
         check("addr", mem_addr_o, ea);
         check("we", mem_we_o, is_store_i && m != AM_ABS_RMW);
         check("rmw", mem_rmw_o, m == AM_ABS_RMW);
         check("x_wr", x_wr_o, m == AM_XINC);
         if (m == AM_XINC)
            check("x_new", x_new_o, 8'(x_i + 8'h01));
      end
   endtask

   task automatic stack_run(input stack_op_t op, input logic [15:0] pc);
      @(posedge clk_i);
      #1;
      stack_op_i = op;
      ret_pc_i = pc;
      @(posedge clk_i);
      #1;
      stack_op_i = SOP_NONE;
      ret_pc_i = ~pc;
      check("busy_start", stack_busy_o, 1'b1);
      wa.delete();
      wd.delete();
      npc = 0;
      npsw = 0;
      jw = -1;
      for (int k = 0; k < 8; k++)
      begin
         if (mem_req_o === 1'b1 && mem_we_o === 1'b1)
         begin
            wa.push_back(mem_addr_o);
            wd.push_back(mem_wdata_o);
         end
         if (jump_ok_o === 1'b1)
            jw = wa.size();
         if (pc_load_o === 1'b1)
         begin
            npc++;
            pcv = pc_new_o;
         end
         if (psw_load_o === 1'b1)
         begin
            npsw++;
            pswv = psw_new_o;
         end
         @(posedge clk_i);
         #1;
      end
      check("busy_end", stack_busy_o, 1'b0);
   endtask

   task automatic call_chk(input logic [15:0] pc);
      stack_run(SOP_CALL, pc);
      check("push_count", 16'(wa.size()), 16'd2);
      check("jump_after_push", 16'(jw), 16'd2);
      check("push_hi_addr", wa[0], {STACK_PAGE, 8'(sp_m)});
      check("push_hi_data", wd[0], pc[15:8]);
      check("push_lo_addr", wa[1], {STACK_PAGE, 8'(sp_m - 1)});
      check("push_lo_data", wd[1], pc[7:0]);
      sp_m = sp_m - 2;
      check("sp_after_call", stack_pointer_o, 8'(sp_m));
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   initial
   begin
      {n_mismatch, n_compared, cycles} = '0;
      seed = 19;
      {rstn_i, req_i, is_store_i, page_sel_i, sp_load_i} = '0;
      ce_i = 1'b1;
      mode_i = AM_REG;
      reg_sel_i = RSEL_ACC;
      stack_op_i = SOP_NONE;
      {op1_i, op2_i, acc_i, x_i, y_i, psw_i, sp_load_val_i} = '0;
      ret_pc_i = 16'h0000;
      repeat (4) @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      check("sp_reset", stack_pointer_o, `OPA_SP_RESET);
      for (int i = 0; i < 45; i++)
         addr_op(addr_mode_t'(i % 9));
      @(posedge clk_i);
      #1;
      sp_m = 8'h40 + ($random(seed) & 8'h1F);
      sp_load_val_i = 8'(sp_m);
      sp_load_i = 1'b1;
      @(posedge clk_i);
      #1;
      // Clock enable low must hold the pointer against a pending load
      ce_i = 1'b0;
      sp_load_val_i = ~sp_load_val_i;
      repeat (2) @(posedge clk_i);
      #1;
      check("sp_frozen", stack_pointer_o, 8'(sp_m));
      sp_load_i = 1'b0;
      ce_i = 1'b1;
      for (int j = 0; j < 3; j++)
      begin
         pa = 16'($random(seed));
         call_chk(pa);
         stack_run(SOP_RET, 16'h0000);
         sp_m = sp_m + 2;
         check("ret_pc_loads", 16'(npc), 16'd1);
         check("ret_pc", pcv, pa);
         check("ret_no_psw", 16'(npsw), 16'd0);
         check("ret_no_write", 16'(wa.size()), 16'd0);
         check("sp_after_ret", stack_pointer_o, 8'(sp_m));
      end
      pa = 16'($random(seed));
      pb = 16'($random(seed));
      call_chk(pa);
      call_chk(pb);
      // Frame built by two calls: flags byte sits lowest, then pc low, high
      stack_run(SOP_RETURN_FROM_INTERRUPT, 16'h0000);
      sp_m = sp_m + 3;
      check("return_from_interrupt_pc_loads", 16'(npc), 16'd1);
      check("return_from_interrupt_pc", pcv, {pa[7:0], pb[15:8]});
      check("return_from_interrupt_psw_loads", 16'(npsw), 16'd1);
      check("return_from_interrupt_psw", pswv, pb[7:0]);
      check("sp_after_return_from_interrupt", stack_pointer_o, 8'(sp_m));
      summarize();
   end
endmodule // cpu_operand_address_and_stack_bench
